/* File: src/jsl_map.vh */
// Purpose: constants for the link initialisation controller
// Assumes: 125 MHz mclk
// Notes: sync source select codes and lane state encodings
`ifndef JSL_MAP_VH
`define JSL_MAP_VH
`define JSL_SRC_SINGLE 2'h0
`define JSL_SRC_DIFF 2'h1
`define JSL_SRC_TSTAMP 2'h2
`define JSL_ST_IDLE 2'h0
`define JSL_ST_CGS 2'h1
`define JSL_ST_ILAS 2'h2
`define JSL_ST_DATA 2'h3
`define JSL_ILAS_CYCLES 8'h08
`endif

/* File: src/jsl_link_init.v */
// Purpose: transmit-side link initialisation driven by the receiver sync request
// Assumes: the sync, timestamp and sysref pins arrive asynchronous to mclk and pass a three-stage synchroniser
// Notes: lane_state output tells the serial lanes what to send
`timescale 1ns/100ps
`default_nettype none
`include "jsl_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - With source select 0 in 8B/10B mode the single-ended sync pin is an active-low request.
// - In 64B/66B mode the sync request is ignored and never steers initialisation.
// - In 8B/10B mode a low sync request starts code group synchronisation.
// - The receiver releases sync high after sync completes and the rise starts lane alignment.
// - The sysref receiver can be powered down by its enable when sysref is unused.
// - The timestamp pair may serve as a differential sync source in 8B/10B mode.
module jsl_link_init #(
	parameter [7:0] ILAS_CYCLES = `JSL_ILAS_CYCLES
)(
	input wire mclk,
	input wire srst,
	input wire mode_64b66b,
	input wire [1:0] sync_source_select,
	input wire single_ended_link_sync_n,
	input wire differential_link_sync_n,
	input wire timestamp_pair_n,
	input wire sysref_receiver_enable,
	input wire sysref_in,
	output wire sysref_rx_powerdown,
	output wire sysref_pulse,
	output wire [1:0] lane_state,
	output wire cgs_active,
	output wire ilas_active
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers, three stages each
localparam PIN_SE = 0;
localparam PIN_DF = 1;
localparam PIN_TS = 2;
localparam PIN_SR = 3;

// Sync pins rest high (released) and sysref rests low, so reset shows no request
localparam [3:0] PIN_REST = 4'h7;

wire [3:0] pin_raw;
wire [3:0] pin_q;

assign pin_raw[PIN_SE] = single_ended_link_sync_n;
assign pin_raw[PIN_DF] = differential_link_sync_n;
assign pin_raw[PIN_TS] = timestamp_pair_n;

// Gated ahead of the synchroniser so a powered-down receiver leaves no stray edge
assign pin_raw[PIN_SR] = sysref_in & sysref_receiver_enable;

genvar gi;

generate
	for (gi = 0; gi < 4; gi = gi + 1)
	begin : g_sync
		reg [2:0] stg_ff;
		reg q_ff;

		// A change counts once stages two and three agree; one-cycle glitches are dropped
		always @(posedge mclk)
		begin
			if (srst)
			begin
				stg_ff <= {3{PIN_REST[gi]}};
				q_ff <= PIN_REST[gi];
			end
			else
			begin
				stg_ff <= {stg_ff[1:0], pin_raw[gi]};
				if (stg_ff[1] == stg_ff[2])
					q_ff <= stg_ff[2];
			end
		end

		assign pin_q[gi] = q_ff;
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Sysref edge detector; reset low matches the gated idle level, so no false edge
reg sr_prev_ff;

always @(posedge mclk)
begin
	if (srst)
		sr_prev_ff <= 1'h0;
	else
		sr_prev_ff <= pin_q[PIN_SR];
end

////////////////////////////////////////////////////////////////////////////////
// Decoding helpers
function pick_sync;
	input [1:0] sel;
	input [3:0] q;
	begin
		case (sel)
			`JSL_SRC_SINGLE: pick_sync = q[PIN_SE];
			`JSL_SRC_DIFF: pick_sync = q[PIN_DF];
			`JSL_SRC_TSTAMP: pick_sync = q[PIN_TS];
			default: pick_sync = 1'b1;
		endcase
	end
endfunction

function lane_is;
	input [1:0] st;
	input [1:0] want;
	begin
		lane_is = (st == want);
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Source selection; unknown codes fall back to no request
reg sync_n;

always @*
begin
	sync_n = pick_sync(sync_source_select, pin_q);
end

// 64B/66B masks the request so a stray pin level cannot restart the link
wire req_low;

assign req_low = ~sync_n & ~mode_64b66b;

////////////////////////////////////////////////////////////////////////////////
// Initialisation state machine
localparam [1:0] ST_IDLE = `JSL_ST_IDLE;
localparam [1:0] ST_CGS = `JSL_ST_CGS;
localparam [1:0] ST_ILAS = `JSL_ST_ILAS;
localparam [1:0] ST_DATA = `JSL_ST_DATA;

reg [1:0] state_ff, nxt_state;
reg [7:0] cnt_ff, nxt_cnt;

always @*
begin
	nxt_state = state_ff;
	nxt_cnt = cnt_ff;
	case (state_ff)
		ST_IDLE:
		begin
			if (mode_64b66b)
				nxt_state = ST_DATA;
			else if (req_low)
				nxt_state = ST_CGS;
		end
		ST_CGS:
		begin
			if (mode_64b66b)
				nxt_state = ST_DATA;
			else if (!req_low)
			begin
				nxt_state = ST_ILAS;
				nxt_cnt = 8'h00;
			end
		end
		ST_ILAS:
		begin
			if (mode_64b66b)
				nxt_state = ST_DATA;
			else if (req_low)
				nxt_state = ST_CGS;
			else if (cnt_ff == ILAS_CYCLES - 8'h01)
				nxt_state = ST_DATA;
			else
				nxt_cnt = cnt_ff + 8'h01;
		end
		ST_DATA:
		begin
			if (req_low)
				nxt_state = ST_CGS;
		end
		default: nxt_state = ST_IDLE;
	endcase
end

// Phase flags are registered from the next state so they line up with lane_state
reg cgs_ff;
reg ilas_ff;

always @(posedge mclk)
begin
	if (srst)
	begin
		state_ff <= ST_IDLE;
		cnt_ff <= 8'h00;
		cgs_ff <= 1'h0;
		ilas_ff <= 1'h0;
	end
	else
	begin
		state_ff <= nxt_state;
		cnt_ff <= nxt_cnt;
		cgs_ff <= lane_is(nxt_state, ST_CGS);
		ilas_ff <= lane_is(nxt_state, ST_ILAS);
	end
end

////////////////////////////////////////////////////////////////////////////////
// Outputs
assign lane_state = state_ff;
assign cgs_active = cgs_ff;
assign ilas_active = ilas_ff;

// Powerdown is a plain level so software sees it follow the enable at once
assign sysref_rx_powerdown = ~sysref_receiver_enable;
assign sysref_pulse = pin_q[PIN_SR] & ~sr_prev_ff;

endmodule // jsl_link_init
`default_nettype wire

/* File: verif/jsl_chk_properties.sv */
// Purpose: timing checks of the link init controller
// Assumes: one mclk domain, srst high clears
// Notes: pin to state takes five edges
`timescale 1ns/100ps
`default_nettype none
module jsl_chk(
	input wire logic mclk,
	input wire logic srst,
	input wire logic mode_64b66b,
	input wire logic [1:0] sync_source_select,
	input wire logic single_ended_link_sync_n,
	input wire logic timestamp_pair_n,
	input wire logic sysref_receiver_enable,
	input wire logic sysref_rx_powerdown,
	input wire logic [1:0] lane_state,
	input wire logic cgs_active,
	input wire logic ilas_active,
	input wire logic sysref_pulse
);
default clocking @(posedge mclk); endclocking
default disable iff (srst);
wire logic e8 = !mode_64b66b && sync_source_select == 2'h0;
pd_follow_a: assert property (sysref_rx_powerdown == !sysref_receiver_enable) else $error("pd");
cgs_start_a: assert property (e8 && $fell(single_ended_link_sync_n) |-> ##5 lane_state == 2'h1)
	else $error("no cgs");
cgs_hold_a: assert property ((e8 && !single_ended_link_sync_n)[*6] |-> lane_state == 2'h1)
	else $error("left cgs");
ilas_go_a: assert property (e8 && lane_state == 2'h1 && $rose(single_ended_link_sync_n)
	|-> ##5 lane_state == 2'h2) else $error("no ilas");
wide_data_a: assert property (mode_64b66b[*2] |-> lane_state == 2'h3) else $error("64b");
tstamp_cgs_a: assert property (sync_source_select == 2'h2 && !mode_64b66b && $fell(timestamp_pair_n)
	|-> ##5 lane_state == 2'h1) else $error("ts");
se_ignored_a: assert property (sync_source_select == 2'h2 && timestamp_pair_n && lane_state == 2'h3
	&& $fell(single_ended_link_sync_n) |-> ##5 lane_state == 2'h3) else $error("se");
phase_flags_a: assert property (cgs_active == (lane_state == 2'h1) && ilas_active == (lane_state == 2'h2))
	else $error("flags");
ilas_length_a: assert property ($rose(ilas_active) |-> ilas_active[*8] ##1 !ilas_active)
	else $error("ilas length");
sysref_single_a: assert property (sysref_pulse |=> !sysref_pulse) else $error("pulse");
endmodule // jsl_chk
bind jsl_link_init jsl_chk u_jsl_chk(.mclk(mclk), .srst(srst), .mode_64b66b(mode_64b66b),
	.sync_source_select(sync_source_select), .single_ended_link_sync_n(single_ended_link_sync_n),
	.timestamp_pair_n(timestamp_pair_n), .sysref_receiver_enable(sysref_receiver_enable),
	.sysref_rx_powerdown(sysref_rx_powerdown), .lane_state(lane_state),
	.cgs_active(cgs_active), .ilas_active(ilas_active), .sysref_pulse(sysref_pulse));
`default_nettype wire

/* File: verif/jsl_rx_model.sv */
// Purpose: far-end receiver driving the sync request
// Assumes: req and tie change at negedge
// Notes: release latched until req drops
`timescale 1ns/100ps
`default_nettype none
module jsl_rx_model(
	input wire logic mclk,
	input wire logic req,
	input wire logic tie,
	input wire logic cgs_active,
	input wire logic [3:0] hold,
	output logic sync_n
);
logic [3:0] seen_ff = 4'h0;
initial sync_n = 1'b1;
always @(posedge mclk)
begin
	if (!req) seen_ff <= 4'h0;
	else if (cgs_active && seen_ff != 4'hF) seen_ff <= seen_ff + 4'h1;
	// Tie low when another source is used; release after sync characters seen
	sync_n <= !(tie || (req && seen_ff <= hold));
end
endmodule // jsl_rx_model
`default_nettype wire

/* File: verif/jsl_link_init_tb_top.sv */
// Purpose: self-checking bench of the link init controller
// Assumes: inputs driven at negedge
// Notes: watcher compares each lane_state change to the queue
`timescale 1ns/100ps
`default_nettype none
module jsl_link_init_tb_top;
logic mclk = 0, srst = 1, mode = 0, req = 0, tie = 0, tsn = 1, sre = 0, srin = 0;
logic [1:0] sel = 2'h0, prev = 2'h0;
logic [3:0] hold = 4'h1;
wire logic sen, pd, ca, sp;
int np = 0;
wire logic [1:0] ls;
logic [1:0] q[$];
int errors = 0, n_checks = 0;
always #4 mclk = ~mclk;
jsl_rx_model u_jsl_rx_model(.mclk(mclk), .req(req), .tie(tie), .cgs_active(ca), .hold(hold),
	.sync_n(sen));
jsl_link_init u_jsl_link_init(.mclk(mclk), .srst(srst), .mode_64b66b(mode),
	.sync_source_select(sel), .single_ended_link_sync_n(sen), .differential_link_sync_n(1'b1),
	.timestamp_pair_n(tsn), .sysref_receiver_enable(sre), .sysref_in(srin),
	.sysref_rx_powerdown(pd), .sysref_pulse(sp), .lane_state(ls), .cgs_active(ca), .ilas_active());
task chk(input logic [1:0] got, input logic [1:0] exp);
	n_checks++;
	if (got !== exp)
	begin
		errors++;
		$display("BAD %0t got %h exp %h", $time, got, exp);
	end
endtask
task complete_run;
	$display("checks %0d errors %0d", n_checks, errors);
	if (errors == 0 && n_checks > 0) $display("Regression OK");
	else $display("Regression broken");
	$finish;
endtask
// A bounded wait: a hang ends the run as a failure
task drain(input string t);
	for (int k = 0; k < 300 && q.size() != 0; k++) @(negedge mclk);
	if (q.size() != 0)
	begin
		errors++;
		$display("BAD %0t hang", $time);
		complete_run;
	end
	$display("test %s done", t);
endtask
always @(negedge mclk)
	if (!srst && ls !== prev)
	begin
		prev = ls;
		chk(ls, q.size() != 0 ? q.pop_front() : 2'hX);
	end
initial
begin
	void'($urandom(32'h9CFA));
	repeat (20) @(negedge mclk);
	srst = 0;
	chk({1'b0, pd}, 2'h1);
	hold = 4'($urandom_range(1, 8));
	q = '{2'h1, 2'h2, 2'h3};
	req = 1;
	drain("sync");
	req = 0;
	sel = 2'h2;
	tie = 1;
	repeat (10) @(negedge mclk);
	chk(ls, 2'h3);
	q = '{2'h1, 2'h2, 2'h3};
	tsn = 0;
	repeat (10) @(negedge mclk);
	tsn = 1;
	drain("tstamp");
	mode = 1;
	sel = 2'h0;
	repeat (12) @(negedge mclk);
	chk(ls, 2'h3);
	$display("test wide done");
	sre = 1;
	srin = 1;
	@(negedge mclk);
	chk({1'b0, pd}, 2'h0);
	for (int k = 0; k < 12; k++)
	begin
		if (sp === 1'b1) np++;
		@(negedge mclk);
	end
	chk(np[1:0], 2'h1);
	$display("test sysref done");
	complete_run;
end
endmodule // jsl_link_init_tb_top
`default_nettype wire
